// ===== src/lpw_pkg.sv
/*
  shared constants and types for the low-power wake control block.
  assumes one 100 MHz clock; no software-visible registers.
*/
package lpw_pkg;
	localparam int CLK_PERIOD_NS = 10;
	// halt wake needs crystal start-up plus this many oscillator cycles of low
	localparam int HALT_EXTRA_CYC = 2;
	// standby low pulse needs this many cycles plus the qualify count
	localparam int STBY_BASE_CYC = 2;
	// crystal start-up time, in ns
	localparam int XTAL_STARTUP_NS = 1000;
	localparam int XTAL_STARTUP_CYC = (XTAL_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HALT_LOW_CYC = XTAL_STARTUP_CYC + HALT_EXTRA_CYC;
	localparam int CNT_W = 16;
	localparam int QUAL_W = 8;
	localparam logic [QUAL_W-1:0] QUAL_RESET = 8'h00;

	// low_power_state request encoding
	typedef enum logic [1:0]
	{
		LPW_RUN = 2'b00,
		LPW_IDLE = 2'b01,
		LPW_STANDBY = 2'b10,
		LPW_HALT = 2'b11
	} lpw_mode_t;
endpackage

// ===== src/lpw_pin_if.sv
/*
  interface carrying the conditioned wake pin between the top and the detector.
  assumes a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface lpw_pin_if;
	logic level;
	logic fall;
	logic rise;
	logic [lpw_pkg::CNT_W-1:0] low_count;
	modport src (output level, output fall, output rise, output low_count);
	modport dst (input level, input fall, input rise, input low_count);
endinterface
`default_nettype wire

// ===== src/lpw_pin_watch.sv
/*
  watches the wake pin: registered level, edge pulses, and length of the current low.
  assumes the pin is synchronous to clock_in.
*/
`timescale 1ns/1ps
`default_nettype none
module lpw_pin_watch
	import lpw_pkg::*;
(
	// clock and reset
	input wire logic clock_in,
	input wire logic nrst_in,
	// pin
	input wire logic wake_pin_in,
	lpw_pin_if.src pin
);
	logic level_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	wire cnt_full = &cnt_q;

	// count saturates so a very long low never wraps back to short
	assign cnt_d = wake_pin_in ? '0 : (cnt_full ? cnt_q : cnt_q + 1'b1);

	always_ff @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			level_q <= 1'b1;
			cnt_q <= '0;
		end
		else
		begin
			level_q <= wake_pin_in;
			cnt_q <= cnt_d;
		end
	end

	assign pin.level = level_q;
	assign pin.fall = level_q & ~wake_pin_in;
	assign pin.rise = ~level_q & wake_pin_in;
	assign pin.low_count = cnt_q;
endmodule
`default_nettype wire

// ===== src/lpw_wake_ctrl.sv
/*
  wake control for halt, idle and standby low-power states.
  assumes the outside agent holds the wake pin high before entry; one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lpw_wake_ctrl
	import lpw_pkg::*;
#(
	parameter int HALT_LOW_CYCLES = HALT_LOW_CYC
)
(
	// clock and reset
	input wire logic clock_in,
	input wire logic nrst_in,
	// state request from the core
	input wire logic enter_in,
	input wire lpw_pkg::lpw_mode_t mode_in,
	input wire logic [lpw_pkg::QUAL_W-1:0] standby_qualify_count_in,
	input wire logic wake_src_en_in,
	input wire logic ext_int_one_en_in,
	// wake pin
	input wire logic wake_pin_in,
	// results
	output logic [1:0] low_power_state_out,
	output logic wake_out,
	output logic wake_interrupt_out,
	output logic external_interrupt_one_out
);
	// the saturating low counter must be able to reach the halt threshold
	if (HALT_LOW_CYCLES < 1 || HALT_LOW_CYCLES >= (1 << CNT_W) - 1)
	begin
		$error("HALT_LOW_CYCLES out of range");
	end

	lpw_pin_if pin();

	lpw_pin_watch u_watch
	(
		.clock_in(clock_in),
		.nrst_in(nrst_in),
		.wake_pin_in(wake_pin_in),
		.pin(pin)
	);

	lpw_mode_t state_q;
	lpw_mode_t state_d;
	logic armed_q;
	logic qual_seen_q;
	logic [QUAL_W-1:0] qual_q;
	logic wake_q;
	logic wint_q;
	logic xint_q;

	// true once the current low, this cycle included, has lasted need cycles
	function automatic logic low_reached(input logic [CNT_W-1:0] count,
		input logic [CNT_W:0] need);
		return ({1'b0, count} + (CNT_W+1)'(1)) >= need;
	endfunction

	// count has one cycle of lag: value seen is cycles already low before now
	wire [CNT_W:0] halt_need = (CNT_W+1)'(HALT_LOW_CYCLES);
	wire [CNT_W:0] stby_need = CNT_W'(STBY_BASE_CYC) + qual_q;
	wire halt_ok = armed_q && low_reached(pin.low_count, halt_need);
	wire stby_ok = armed_q && low_reached(pin.low_count, stby_need);
	wire in_halt = state_q == LPW_HALT;
	wire in_stby = state_q == LPW_STANDBY;
	wire in_idle = state_q == LPW_IDLE;
	wire halt_wake = in_halt && !wake_pin_in && halt_ok;
	wire stby_wake = in_stby && pin.rise && qual_seen_q;
	wire idle_wake = in_idle && ext_int_one_en_in && pin.fall;
	wire any_wake = halt_wake || stby_wake || idle_wake;

	// entry is refused outside run; only a wake leaves a low-power state
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			LPW_RUN:
				if (enter_in)
					state_d = mode_in;
			LPW_IDLE, LPW_STANDBY, LPW_HALT:
				if (any_wake)
					state_d = LPW_RUN;
		endcase
	end

	always_ff @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			state_q <= LPW_RUN;
			armed_q <= 1'b0;
			qual_seen_q <= 1'b0;
			qual_q <= QUAL_RESET;
			wake_q <= 1'b0;
			wint_q <= 1'b0;
			xint_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			if (state_q == LPW_RUN && enter_in)
				qual_q <= standby_qualify_count_in;
			// a low already present at entry is not a wake event
			if (state_q == LPW_RUN)
				armed_q <= 1'b0;
			else if (wake_pin_in)
				armed_q <= 1'b1;
			if (state_q != LPW_STANDBY || wake_pin_in)
				qual_seen_q <= qual_seen_q && in_stby && !stby_wake;
			else if (stby_ok)
				qual_seen_q <= 1'b1;
			wake_q <= any_wake;
			wint_q <= wake_src_en_in && (halt_wake || stby_wake);
			xint_q <= idle_wake;
		end
	end

	assign low_power_state_out = state_q;
	assign wake_out = wake_q;
	assign wake_interrupt_out = wint_q;
	assign external_interrupt_one_out = xint_q;

	sequence s_halt_low;
		in_halt && armed_q && !wake_pin_in;
	endsequence

	property p_halt_wake;
		@(posedge clock_in) disable iff (!nrst_in)
		halt_wake |=> wake_out && low_power_state_out == LPW_RUN;
	endproperty
	a_halt_wake: assert property (p_halt_wake) else $error("halt wake missed");

	property p_halt_early;
		@(posedge clock_in) disable iff (!nrst_in)
		s_halt_low ##0 (pin.low_count + 1 < HALT_LOW_CYCLES) |=> !wake_out;
	endproperty
	a_halt_early: assert property (p_halt_early) else $error("halt woke too early");

	property p_stby_rise;
		@(posedge clock_in) disable iff (!nrst_in)
		in_stby && pin.rise && qual_seen_q |=> wake_out ##1 !wake_out;
	endproperty
	a_stby_rise: assert property (p_stby_rise) else $error("standby wake missed");

	property p_stby_low;
		@(posedge clock_in) disable iff (!nrst_in)
		in_stby && !wake_pin_in |=> !wake_out;
	endproperty
	a_stby_low: assert property (p_stby_low) else $error("standby woke while low");

	property p_idle_fall;
		@(posedge clock_in) disable iff (!nrst_in)
		in_idle && ext_int_one_en_in && $fell(wake_pin_in) && !pin.level == 0
			|=> external_interrupt_one_out && wake_out;
	endproperty
	a_idle_fall: assert property (p_idle_fall) else $error("idle wake missed");

	property p_wint_src;
		@(posedge clock_in) disable iff (!nrst_in)
		wake_interrupt_out |-> $past(wake_src_en_in) && $past(state_q) inside {LPW_HALT, LPW_STANDBY};
	endproperty
	a_wint_src: assert property (p_wint_src) else $error("wake interrupt without cause");

	property p_arm;
		@(posedge clock_in) disable iff (!nrst_in)
		state_q == LPW_RUN && enter_in && !wake_pin_in |=> !wake_out;
	endproperty
	a_arm: assert property (p_arm) else $error("woke on low held at entry");

	property p_idle_no_wint;
		@(posedge clock_in) disable iff (!nrst_in)
		idle_wake |=> !wake_interrupt_out;
	endproperty
	a_idle_no_wint: assert property (p_idle_no_wint) else $error("wake interrupt from idle");

	property p_halt_high;
		@(posedge clock_in) disable iff (!nrst_in)
		in_halt && wake_pin_in |=> low_power_state_out == LPW_HALT;
	endproperty
	a_halt_high: assert property (p_halt_high) else $error("halt left while high");

	property p_stby_hold;
		@(posedge clock_in) disable iff (!nrst_in)
		in_stby && !pin.rise |=> low_power_state_out == LPW_STANDBY;
	endproperty
	a_stby_hold: assert property (p_stby_hold) else $error("standby left early");

	property p_stby_unqual;
		@(posedge clock_in) disable iff (!nrst_in)
		in_stby && pin.rise && !qual_seen_q |=> !wake_out;
	endproperty
	a_stby_unqual: assert property (p_stby_unqual) else $error("unqualified wake");

	property p_idle_masked;
		@(posedge clock_in) disable iff (!nrst_in)
		in_idle && !ext_int_one_en_in |=> !wake_out && low_power_state_out == LPW_IDLE;
	endproperty
	a_idle_masked: assert property (p_idle_masked) else $error("idle wake masked");

	property p_xint_idle;
		@(posedge clock_in) disable iff (!nrst_in)
		external_interrupt_one_out |-> $past(state_q) == LPW_IDLE;
	endproperty
	a_xint_idle: assert property (p_xint_idle) else $error("interrupt outside idle");

	property p_wint_off;
		@(posedge clock_in) disable iff (!nrst_in)
		!wake_src_en_in |=> !wake_interrupt_out;
	endproperty
	a_wint_off: assert property (p_wint_off) else $error("wake interrupt while off");

	property p_wake_single;
		@(posedge clock_in) disable iff (!nrst_in)
		wake_out |=> !wake_out;
	endproperty
	a_wake_single: assert property (p_wake_single) else $error("wake pulse too long");
endmodule
`default_nettype wire

// ===== bench/lpw_agent.sv
/*
  outside agent on the wake pin: idles high, then gives one low pulse of len_in cycles.
  assumes go_in is a one-cycle request made just after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module lpw_agent
(
	// clock
	input wire logic clock_in,
	// request
	input wire logic go_in,
	input wire logic [7:0] len_in,
	// pin
	output logic pin_out
);
	logic [7:0] left_q = 8'h00;
	always_ff @(posedge clock_in)
		if (go_in)
			left_q <= len_in;
		else if (left_q != 8'h00)
			left_q <= left_q - 8'h01;
	// high between pulses, low exactly len_in cycles
	assign pin_out = (left_q == 8'h00);
endmodule
`default_nettype wire

// ===== bench/tb_lpw_wake_ctrl.sv
/*
  self-checking bench for the wake control block with a small halt count.
  assumes the agent model above drives the wake pin.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_lpw_wake_ctrl;
	import lpw_pkg::*;
	logic clock_in = 0, nrst_in = 0, enter = 0, src = 0, ext = 0, go = 0, pin;
	logic w, wi, x, sw, swi, sx;
	logic [1:0] st;
	lpw_mode_t mode = LPW_RUN;
	logic [7:0] q = 8'h00, len = 8'h00;
	int errors = 0, total_checks = 0;
	lpw_wake_ctrl #(.HALT_LOW_CYCLES(4)) lpw_wake_ctrl_inst (.clock_in(clock_in),
		.nrst_in(nrst_in), .enter_in(enter), .mode_in(mode), .standby_qualify_count_in(q),
		.wake_src_en_in(src), .ext_int_one_en_in(ext), .wake_pin_in(pin),
		.low_power_state_out(st), .wake_out(w), .wake_interrupt_out(wi),
		.external_interrupt_one_out(x));
	lpw_agent lpw_agent_inst (.clock_in(clock_in), .go_in(go), .len_in(len), .pin_out(pin));
	initial forever #5 clock_in = ~clock_in;
	always @(posedge clock_in)
	begin
		sw = sw | w;
		swi = swi | wi;
		sx = sx | x;
	end
	task automatic chk(input string n, input logic [4:0] seen, input logic [4:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic restart();
		nrst_in = 0;
		@(posedge clock_in) #1;
		nrst_in = 1;
	endtask
	// enter a state, arm on high pin, pulse low, collect pulses; reset afterwards
	task automatic run(input lpw_mode_t m, input logic [7:0] qc, input logic [7:0] l,
		input logic s, input logic e, output logic [4:0] r);
		@(posedge clock_in) #1;
		enter = 1;
		mode = m;
		q = qc;
		src = s;
		ext = e;
		@(posedge clock_in) #1;
		enter = 0;
		{sw, swi, sx} = 3'b000;
		repeat (2) @(posedge clock_in);
		#1 go = 1;
		len = l;
		@(posedge clock_in) #1;
		go = 0;
		repeat (l + 6) @(posedge clock_in);
		#1 r = {sw, swi, sx, st};
		restart();
	endtask
	task automatic halt_wake();
		logic [4:0] r;
		run(LPW_HALT, 8'h00, 8'h08, 1'b1, 1'b1, r);
		chk("halt", r, 5'b11000);
		run(LPW_HALT, 8'h00, 8'h02, 1'b1, 1'b1, r);
		chk("halt_short", r, 5'b00011);
	endtask
	task automatic standby_wake();
		logic [4:0] r;
		run(LPW_STANDBY, 8'h03, 8'h05, 1'b1, 1'b1, r);
		chk("stby", r, 5'b11000);
		run(LPW_STANDBY, 8'h03, 8'h04, 1'b1, 1'b1, r);
		chk("stby_short", r, 5'b00010);
		run(LPW_STANDBY, 8'h00, 8'h02, 1'b0, 1'b1, r);
		chk("stby_nosrc", r, 5'b10000);
	endtask
	task automatic idle_wake();
		logic [4:0] r;
		run(LPW_IDLE, 8'h00, 8'h03, 1'b0, 1'b1, r);
		chk("idle", r, 5'b10100);
		run(LPW_IDLE, 8'h00, 8'h03, 1'b0, 1'b0, r);
		chk("idle_masked", r, 5'b00001);
	endtask
	// pin already low when halt is entered: that low must not wake the block
	task automatic entry_low();
		logic [4:0] r;
		@(posedge clock_in) #1;
		go = 1;
		len = 8'h0A;
		src = 1;
		ext = 1;
		@(posedge clock_in) #1;
		go = 0;
		enter = 1;
		mode = LPW_HALT;
		@(posedge clock_in) #1;
		enter = 0;
		{sw, swi, sx} = 3'b000;
		repeat (12) @(posedge clock_in);
		#1 r = {sw, swi, sx, st};
		chk("halt_entry_low", r, 5'b00011);
		restart();
	endtask
	initial
	begin
		repeat (6) @(posedge clock_in);
		#1 nrst_in = 1;
		halt_wake();
		standby_wake();
		idle_wake();
		entry_low();
		finish_test();
	end
	initial
	begin
		#20000;
		errors++;
		finish_test();
	end
endmodule
`default_nettype wire
